/* rtl/mtfcr_pkg.sv */
// Constants and types shared by the transmitter and flow-control
// configuration bank. Assumes a single 25 MHz management clock.
package mtfcr_pkg;

    // Register offsets on the management interface
    localparam logic [11:0] ADDR_PAUSE_LO = 12'h400;
    localparam logic [11:0] ADDR_PAUSE_HI = 12'h404;
    localparam logic [11:0] ADDR_TX_CFG = 12'h408;
    localparam logic [11:0] ADDR_FC_CFG = 12'h40C;

    // Transmitter configuration word fields
    localparam int TX_RESET_BIT = 31;
    localparam int TX_JUMBO_BIT = 30;
    localparam int TX_FCS_BIT = 29;
    localparam int TX_ENABLE_BIT = 28;
    localparam int TX_VLAN_BIT = 27;
    localparam int TX_HALF_BIT = 26;
    localparam int TX_IFG_ADJ_BIT = 25;
    localparam logic [31:0] TX_CFG_RESET = 32'h1000_0000;
    localparam logic [31:0] TX_CFG_WMASK = 32'h7E00_0000;

    // Flow control configuration word fields
    localparam int FC_TX_LEGACY_BIT = 30;
    localparam int FC_RX_LEGACY_BIT = 29;
    localparam int FC_TX_PFC_BIT = 26;
    localparam int FC_RX_PFC_BIT = 25;
    localparam int FC_AUTO_XON_BIT = 20;
    localparam int FC_TX_PRIO_LSB = 8;
    localparam int FC_RX_PRIO_LSB = 0;
    localparam logic [31:0] FC_RESET_PFC = 32'h6010_FFFF;
    localparam logic [31:0] FC_RESET_LEGACY = 32'h6000_0000;
    localparam logic [31:0] FC_WMASK_PFC = 32'h6610_FFFF;
    localparam logic [31:0] FC_WMASK_LEGACY = 32'h6000_0000;

    // Pause source address after reset, and its split across two words
    localparam logic [47:0] PAUSE_ADDR_RESET = 48'hFFFF_FFFF_FFFF;
    localparam logic [31:0] PAUSE_HI_WMASK = 32'h0000_FFFF;

    // Minimum interframe gap in clock cycles
    localparam int MIN_IFG_CYCLES = 12;

    // Active transmitter settings, applied on frame boundaries
    typedef struct packed {
        logic jumbo;
        logic fcs_inband;
        logic enable;
        logic vlan;
        logic half_duplex;
        logic ifg_adjust;
    } mtfcr_tx_cfg_t;

    // Request for one outbound control frame
    typedef struct packed {
        logic pfc;
        logic xon;
        logic [7:0] prio_mask;
    } mtfcr_ctl_req_t;

    typedef enum logic [1:0] {
        CS_IDLE = 2'b01,
        CS_BUSY = 2'b10
    } mtfcr_ctl_state_t;

endpackage

/* rtl/mtfcr_edge.sv */
// Registered edge detector for a vector of request levels, with a
// per-bit enable. Assumes inputs come from logic on the same clock.
`timescale 1ns/1ps
module mtfcr_edge
    import mtfcr_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Levels and enables
    input wire logic [W-1:0] level_i,
    input wire logic [W-1:0] enable_i,
    // Edge pulses
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    logic [W-1:0] prev;
    wire [W-1:0] gated = level_i & enable_i;

    // Disabling a bit while its level is high is not taken as a fall
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev <= '0;
            rise_o <= '0;
            fall_o <= '0;
        end else begin
            prev <= gated;
            rise_o <= gated & ~prev;
            fall_o <= prev & ~level_i & enable_i;
        end
    end
endmodule

/* rtl/mtfcr_gap.sv */
// Interframe gap timer. Samples the gap request at frame start and
// counts the gap after frame end. Inputs come from the same clock.
`timescale 1ns/1ps
module mtfcr_gap
    import mtfcr_pkg::*;
#(
    parameter int IFG_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Frame markers and gap control
    input wire logic frame_start_i,
    input wire logic frame_end_i,
    input wire logic adjust_i,
    input wire logic [IFG_W-1:0] delay_i,
    // Gap still running
    output logic busy_o
);
    localparam logic [IFG_W-1:0] MIN_GAP = IFG_W'(MIN_IFG_CYCLES);
    logic [IFG_W-1:0] gap_len;
    logic [IFG_W-1:0] count;
    wire [IFG_W-1:0] sampled = (adjust_i && delay_i > MIN_GAP) ?
        delay_i : MIN_GAP;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_len <= MIN_GAP;
            count <= '0;
            busy_o <= 1'b0;
        end else begin
            if (frame_start_i)
                gap_len <= sampled;
            if (frame_end_i) begin
                count <= gap_len;
                busy_o <= 1'b1;
            end else if (count > IFG_W'(1)) begin
                count <= count - IFG_W'(1);
            end else begin
                count <= '0;
                busy_o <= 1'b0;
            end
        end
    end
endmodule

/* rtl/mtfcr_regs.sv */
// Transmitter and flow-control configuration bank with the control
// logic it steers. Assumes all ports are on clk_i (25 MHz); the client,
// the transmit datapath and the receive parser are synchronous logic.
`timescale 1ns/1ps

module mtfcr_regs
    import mtfcr_pkg::*;
#(
    parameter bit PFC_SUPPORT = 1'b1,
    parameter int IFG_W = 8,
    parameter int QUANTA_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Management register port
    input wire logic [11:0] mgmt_addr_i,
    input wire logic mgmt_wr_i,
    input wire logic mgmt_rd_i,
    input wire logic [31:0] mgmt_wdata_i,
    output logic [31:0] mgmt_rdata_o,
    output logic mgmt_rdack_o,
    // Transmit datapath frame markers and settings
    input wire logic tx_frame_start_i,
    input wire logic tx_frame_end_i,
    input wire logic [IFG_W-1:0] ifg_delay_i,
    output mtfcr_tx_cfg_t tx_cfg_o,
    output logic tx_reset_o,
    output logic tx_gap_busy_o,
    output logic tx_inhibit_o,
    // Client flow-control requests
    input wire logic pause_request_i,
    input wire logic [7:0] xmit_prio_pause_valid_i,
    // Control frame request towards the transmitter
    output logic ctl_send_o,
    output mtfcr_ctl_req_t ctl_req_o,
    output logic [47:0] ctl_src_addr_o,
    input wire logic ctl_ack_i,
    // Received control frames from the receive parser
    input wire logic rx_pause_frame_i,
    input wire logic [QUANTA_W-1:0] rx_pause_quanta_i,
    input wire logic rx_pfc_frame_i,
    input wire logic [7:0] rx_pfc_quanta_valid_i,
    output logic [7:0] recv_prio_pause_valid_o,
    output logic rx_ctl_pass_o
);
    localparam logic [31:0] FC_RESET =
        PFC_SUPPORT ? FC_RESET_PFC : FC_RESET_LEGACY;
    localparam logic [31:0] FC_WMASK =
        PFC_SUPPORT ? FC_WMASK_PFC : FC_WMASK_LEGACY;
    localparam mtfcr_tx_cfg_t TX_CFG_DEFAULT = mtfcr_tx_cfg_t'(
        TX_CFG_RESET[TX_JUMBO_BIT:TX_IFG_ADJ_BIT]);

    // Stored register contents
    logic [31:0] tx_cfg_reg;
    logic [31:0] fc_cfg_reg;
    logic [47:0] pause_addr;

    // Frame and control-frame state
    logic frame_active;
    mtfcr_ctl_state_t ctl_state;
    mtfcr_ctl_state_t next_ctl_state;
    logic pend_xoff;
    logic pend_xon;
    logic pend_pfc;
    logic [QUANTA_W-1:0] inhibit_count;

    // Address decode
    wire sel_pause_lo = mgmt_addr_i == ADDR_PAUSE_LO;
    wire sel_pause_hi = mgmt_addr_i == ADDR_PAUSE_HI;
    wire sel_tx_cfg = mgmt_addr_i == ADDR_TX_CFG;
    wire sel_fc_cfg = mgmt_addr_i == ADDR_FC_CFG;

    // Full compare: aliases are not written
    wire wr_pause_lo = mgmt_wr_i && sel_pause_lo;
    wire wr_pause_hi = mgmt_wr_i && sel_pause_hi;
    wire wr_tx_cfg = mgmt_wr_i && sel_tx_cfg;
    wire wr_fc_cfg = mgmt_wr_i && sel_fc_cfg;
    wire tx_soft_reset = wr_tx_cfg && mgmt_wdata_i[TX_RESET_BIT];

    // Reserved bits are masked on the way in so they always read zero
    wire [31:0] next_tx_cfg_reg = tx_soft_reset ? TX_CFG_RESET :
        (mgmt_wdata_i & TX_CFG_WMASK);
    wire [31:0] next_fc_cfg_reg = mgmt_wdata_i & FC_WMASK;

    // Read mux; words outside the bank read as zero
    wire [31:0] rd_pause_hi = {16'h0000, pause_addr[47:32]};
    wire [31:0] rd_mux =
        sel_pause_lo ? pause_addr[31:0] :
        sel_pause_hi ? rd_pause_hi :
        sel_tx_cfg ? tx_cfg_reg :
        sel_fc_cfg ? fc_cfg_reg : 32'h0000_0000;

    // Named flow-control fields
    wire legacy_tx_en = fc_cfg_reg[FC_TX_LEGACY_BIT];
    wire legacy_rx_en = fc_cfg_reg[FC_RX_LEGACY_BIT];
    wire pfc_tx_en = fc_cfg_reg[FC_TX_PFC_BIT];
    wire pfc_rx_en = fc_cfg_reg[FC_RX_PFC_BIT];
    wire auto_resume_frame_enable = fc_cfg_reg[FC_AUTO_XON_BIT];
    wire [7:0] tx_prio_en = fc_cfg_reg[FC_TX_PRIO_LSB +: 8];
    wire [7:0] rx_prio_en = fc_cfg_reg[FC_RX_PRIO_LSB +: 8];

    // Settings held in the register, before the frame-boundary latch
    wire mtfcr_tx_cfg_t staged_cfg =
        mtfcr_tx_cfg_t'(tx_cfg_reg[TX_JUMBO_BIT:TX_IFG_ADJ_BIT]);

    // Settings may be taken only outside a frame, and never on the
    // edge where a frame starts, so one frame sees one set of values
    wire cfg_take = !frame_active && !tx_frame_start_i;

    // Request edges; disabled bits produce no edge at all
    logic [0:0] pause_rise;
    logic [0:0] pause_fall;
    logic [7:0] prio_rise;
    logic [7:0] prio_fall;
    wire [0:0] pause_en = legacy_tx_en;
    wire [7:0] prio_en = pfc_tx_en ? tx_prio_en : 8'h00;

    mtfcr_edge #(
        .W(1)
    ) u_pause_edge (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .level_i(pause_request_i),
        .enable_i(pause_en),
        .rise_o(pause_rise),
        .fall_o(pause_fall)
    );

    mtfcr_edge #(
        .W(8)
    ) u_prio_edge (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .level_i(xmit_prio_pause_valid_i),
        .enable_i(prio_en),
        .rise_o(prio_rise),
        .fall_o(prio_fall)
    );

    // Gap timer follows the settings that the current frame runs with
    logic gap_busy;

    mtfcr_gap #(
        .IFG_W(IFG_W)
    ) u_gap (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .frame_start_i(tx_frame_start_i),
        .frame_end_i(tx_frame_end_i),
        .adjust_i(tx_cfg_o.ifg_adjust),
        .delay_i(ifg_delay_i),
        .busy_o(gap_busy)
    );

    // Control-frame events; a new event survives its own launch cycle
    wire ev_xoff = pause_rise[0];
    wire ev_xon = pause_fall[0] && auto_resume_frame_enable;
    wire ev_pfc = (|prio_rise) || (|prio_fall);
    wire any_pend = pend_xoff || pend_xon || pend_pfc;

    // Control frames wait for the transmitter to be between frames
    wire can_launch = (ctl_state == CS_IDLE) && any_pend &&
        !frame_active && !tx_frame_start_i && tx_cfg_o.enable;
    wire launch_xoff = can_launch && pend_xoff;
    wire launch_xon = can_launch && !pend_xoff && pend_xon;
    wire launch_pfc = can_launch && !pend_xoff && !pend_xon;

    // Clearing a mode drops its queue
    wire next_pend_xoff = legacy_tx_en &&
        ((pend_xoff && !launch_xoff) || ev_xoff);
    wire next_pend_xon = legacy_tx_en &&
        ((pend_xon && !launch_xon) || ev_xon);
    wire next_pend_pfc = pfc_tx_en &&
        ((pend_pfc && !launch_pfc) || ev_pfc);

    // Priorities still asserted get pause quanta; the rest resume
    wire [7:0] live_prio = xmit_prio_pause_valid_i & prio_en;

    always_comb begin
        next_ctl_state = ctl_state;
        unique case (ctl_state)
            CS_IDLE: begin
                if (can_launch)
                    next_ctl_state = CS_BUSY;
            end
            CS_BUSY: begin
                if (ctl_ack_i)
                    next_ctl_state = CS_IDLE;
            end
        endcase
    end

    // Receive side: pause quanta inhibit the transmitter when allowed
    wire rx_pause_take = rx_pause_frame_i && legacy_rx_en;
    wire rx_pfc_take = rx_pfc_frame_i && pfc_rx_en;

    // Disabled priorities stay low
    wire [7:0] next_recv_valid = rx_pfc_take ?
        (rx_pfc_quanta_valid_i & rx_prio_en) : 8'h00;
    wire next_rx_pass = (rx_pause_frame_i && !legacy_rx_en) ||
        (rx_pfc_frame_i && !pfc_rx_en);

    // A new frame restarts the count
    wire [QUANTA_W-1:0] next_inhibit_count =
        rx_pause_take ? rx_pause_quanta_i :
        (inhibit_count != '0) ? inhibit_count - QUANTA_W'(1) :
        inhibit_count;

    // Management registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_cfg_reg <= TX_CFG_RESET;
            fc_cfg_reg <= FC_RESET;
            pause_addr <= PAUSE_ADDR_RESET;
        end else begin
            if (wr_tx_cfg)
                tx_cfg_reg <= next_tx_cfg_reg;
            if (wr_fc_cfg)
                fc_cfg_reg <= next_fc_cfg_reg;
            if (wr_pause_lo)
                pause_addr[31:0] <= mgmt_wdata_i;
            if (wr_pause_hi)
                pause_addr[47:32] <= mgmt_wdata_i[15:0];
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mgmt_rdata_o <= 32'h0000_0000;
            mgmt_rdack_o <= 1'b0;
        end else begin
            mgmt_rdack_o <= mgmt_rd_i;
            if (mgmt_rd_i)
                mgmt_rdata_o <= rd_mux & (sel_pause_hi ? PAUSE_HI_WMASK :
                    32'hFFFF_FFFF);
        end
    end

    // Frame tracking and the settings the datapath actually uses
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_active <= 1'b0;
            tx_cfg_o <= TX_CFG_DEFAULT;
            tx_reset_o <= 1'b0;
        end else begin
            tx_reset_o <= tx_soft_reset;
            if (tx_soft_reset) begin
                // A reset abandons the frame, so defaults apply at once
                frame_active <= 1'b0;
                tx_cfg_o <= TX_CFG_DEFAULT;
            end else begin
                if (tx_frame_start_i)
                    frame_active <= 1'b1;
                else if (tx_frame_end_i)
                    frame_active <= 1'b0;
                if (cfg_take)
                    tx_cfg_o <= staged_cfg;
            end
        end
    end

    // Control-frame sequencer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl_state <= CS_IDLE;
            pend_xoff <= 1'b0;
            pend_xon <= 1'b0;
            pend_pfc <= 1'b0;
            ctl_send_o <= 1'b0;
            ctl_req_o <= '0;
        end else begin
            ctl_state <= next_ctl_state;
            pend_xoff <= next_pend_xoff;
            pend_xon <= next_pend_xon;
            pend_pfc <= next_pend_pfc;
            if (can_launch) begin
                ctl_send_o <= 1'b1;
                ctl_req_o.pfc <= launch_pfc;
                ctl_req_o.xon <= launch_xon;
                // Levels at launch, not at the edge
                ctl_req_o.prio_mask <= launch_pfc ? live_prio : 8'h00;
            end else if (ctl_state == CS_BUSY && ctl_ack_i) begin
                ctl_send_o <= 1'b0;
            end
        end
    end

    // Source address and transmit status outputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl_src_addr_o <= PAUSE_ADDR_RESET;
            tx_gap_busy_o <= 1'b0;
            tx_inhibit_o <= 1'b0;
            inhibit_count <= '0;
        end else begin
            // Follows writes even while a frame waits
            ctl_src_addr_o <= pause_addr;
            tx_gap_busy_o <= gap_busy;
            inhibit_count <= next_inhibit_count;
            tx_inhibit_o <= next_inhibit_count != '0;
        end
    end

    // Receive-side outputs, one cycle after the parser's strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            recv_prio_pause_valid_o <= 8'h00;
            rx_ctl_pass_o <= 1'b0;
        end else begin
            recv_prio_pause_valid_o <= next_recv_valid;
            rx_ctl_pass_o <= next_rx_pass;
        end
    end

    // Mode pairing is left to software: both flow modes may be set
    // together and then both act; pending legacy frames launch ahead of PFC frames

endmodule

/* test/mtfcr_regs_asserts.sv */
// Port-level checker for the configuration bank.
// Assumes one clock domain and the default parameter set.
`timescale 1ns/1ps
module mtfcr_regs_asserts
    import mtfcr_pkg::*;
#(
    parameter int QUANTA_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Management port
    input wire logic [11:0] mgmt_addr_i,
    input wire logic mgmt_wr_i,
    input wire logic mgmt_rd_i,
    input wire logic [31:0] mgmt_wdata_i,
    input wire logic [31:0] mgmt_rdata_o,
    input wire logic mgmt_rdack_o,
    // Transmit side
    input wire logic tx_frame_start_i,
    input wire logic tx_frame_end_i,
    input wire mtfcr_tx_cfg_t tx_cfg_o,
    input wire logic tx_reset_o,
    input wire logic tx_gap_busy_o,
    input wire logic tx_inhibit_o,
    // Flow control
    input wire logic ctl_send_o,
    input wire mtfcr_ctl_req_t ctl_req_o,
    input wire logic ctl_ack_i,
    input wire logic rx_pause_frame_i,
    input wire logic [QUANTA_W-1:0] rx_pause_quanta_i,
    input wire logic rx_pfc_frame_i,
    input wire logic [7:0] rx_pfc_quanta_valid_i,
    input wire logic [7:0] recv_prio_pause_valid_o,
    input wire logic rx_ctl_pass_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic in_frame;
    logic [7:0] gap_run;
    wire tx_rst_wr = mgmt_wr_i && mgmt_addr_i == ADDR_TX_CFG
        && mgmt_wdata_i[TX_RESET_BIT];
    wire rd_fc = mgmt_rd_i && mgmt_addr_i == ADDR_FC_CFG;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_frame <= 1'b0;
            gap_run <= 8'h00;
        end else begin
            in_frame <= tx_frame_start_i | (in_frame & ~tx_frame_end_i);
            gap_run <= tx_gap_busy_o ? gap_run + 8'h01 : 8'h00;
        end
    end

    sequence s_rd_tx;
        mgmt_rd_i && mgmt_addr_i == ADDR_TX_CFG;
    endsequence
    sequence s_gap_hold;
        tx_gap_busy_o [*8];
    endsequence

    reset_pulse_a: assert property (tx_rst_wr |-> ##[1:2] tx_reset_o)
        else $error("transmitter reset pulse missing");
    tx_reserved_a: assert property (s_rd_tx |=> mgmt_rdack_o
        && (mgmt_rdata_o & 32'h81FF_FFFF) == 32'h0)
        else $error("transmit word reserved bits not zero");
    fc_reserved_a: assert property (rd_fc |=> mgmt_rdack_o
        && (mgmt_rdata_o & 32'h99EF_0000) == 32'h0)
        else $error("flow word reserved bits not zero");
    ctl_hold_a: assert property (ctl_send_o && !ctl_ack_i
        |=> ctl_send_o && $stable(ctl_req_o))
        else $error("control request dropped before accept");
    ctl_release_a: assert property (ctl_send_o && ctl_ack_i
        |=> !ctl_send_o)
        else $error("control request held after accept");
    send_enable_a: assert property ($rose(ctl_send_o) |-> tx_cfg_o.enable)
        else $error("control frame sent while disabled");
    cfg_frozen_a: assert property ((tx_frame_start_i || in_frame)
        && !tx_rst_wr |=> $stable(tx_cfg_o))
        else $error("settings changed inside a frame");
    gap_min_a: assert property ($fell(tx_gap_busy_o)
        |-> gap_run >= MIN_IFG_CYCLES)
        else $error("interframe gap too short");
    gap_start_a: assert property (tx_frame_end_i |-> ##[1:3] s_gap_hold)
        else $error("gap not started after frame end");
    rx_valid_gate_a: assert property (rx_pfc_frame_i |=>
        (recv_prio_pause_valid_o & ~$past(rx_pfc_quanta_valid_i)) == 8'h00)
        else $error("receive valid without valid quanta");
    rx_valid_idle_a: assert property (!rx_pfc_frame_i
        |=> recv_prio_pause_valid_o == 8'h00)
        else $error("receive valid without a frame");
    pause_answer_a: assert property (rx_pause_frame_i
        && rx_pause_quanta_i != 0 |=> tx_inhibit_o != rx_ctl_pass_o)
        else $error("pause frame neither inhibits nor passes");
endmodule

bind mtfcr_regs mtfcr_regs_asserts #(.QUANTA_W(QUANTA_W)) u_asserts (.*);

/* test/mtfcr_ack_model.sv */
// Far-side transmitter: accepts control frame requests after a set
// number of cycles. Assumes the bank's clock and reset.
`timescale 1ns/1ps
module mtfcr_ack_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Request and answer
    input wire logic ctl_send_i,
    input wire logic [3:0] delay_i,
    output logic ctl_ack_o
);
    logic [3:0] wait_cnt;
    wire waiting = ctl_send_i && !ctl_ack_o;
    wire accept = waiting && wait_cnt == delay_i;

    // Counter restarts per request so slow answers stay repeatable
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_cnt <= 4'h0;
            ctl_ack_o <= 1'b0;
        end else begin
            ctl_ack_o <= accept;
            wait_cnt <= (waiting && !accept) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule

/* test/mtfcr_regs_test.sv */
// Self-checking bench for the configuration bank.
// Assumes a 25 MHz clock and the far-side model in mtfcr_ack_model.
`timescale 1ns/1ps
module mtfcr_regs_test;
    import mtfcr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] mgmt_addr_i = 12'h000;
    logic mgmt_wr_i = 1'b0;
    logic mgmt_rd_i = 1'b0;
    logic [31:0] mgmt_wdata_i = 32'h0;
    logic [31:0] mgmt_rdata_o;
    logic mgmt_rdack_o;
    logic tx_frame_start_i = 1'b0;
    logic tx_frame_end_i = 1'b0;
    logic [7:0] ifg_delay_i = 8'h00;
    mtfcr_tx_cfg_t tx_cfg_o;
    logic tx_reset_o;
    logic tx_gap_busy_o;
    logic tx_inhibit_o;
    logic pause_request_i = 1'b0;
    logic [7:0] xmit_prio_pause_valid_i = 8'h00;
    logic ctl_send_o;
    mtfcr_ctl_req_t ctl_req_o;
    logic [47:0] ctl_src_addr_o;
    logic ctl_ack_i;
    logic rx_pause_frame_i = 1'b0;
    logic [15:0] rx_pause_quanta_i = 16'h0000;
    logic rx_pfc_frame_i = 1'b0;
    logic [7:0] rx_pfc_quanta_valid_i = 8'h00;
    logic [7:0] recv_prio_pause_valid_o;
    logic rx_ctl_pass_o;
    logic [3:0] ack_dly = 4'h0;
    int err_total = 0;
    int cmp_count = 0;
    integer seed = 32'hded3;
    logic [31:0] d, r;
    logic [31:0] a_lo = 32'hFFFF_FFFF;
    logic [31:0] a_hi = 32'hFFFF_FFFF;
    int n;

    always #20 clk_i = ~clk_i;

    mtfcr_regs dut (.*);
    mtfcr_ack_model partner (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .ctl_send_i(ctl_send_o), .delay_i(ack_dly), .ctl_ack_o(ctl_ack_i));

    task automatic chk(input string what, input logic [63:0] got,
                       input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_i);
        mgmt_addr_i <= a;
        mgmt_wdata_i <= v;
        mgmt_wr_i <= 1'b1;
        @(posedge clk_i);
        mgmt_wr_i <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_i);
        mgmt_addr_i <= a;
        mgmt_rd_i <= 1'b1;
        @(posedge clk_i);
        mgmt_rd_i <= 1'b0;
        #1;
        chk("rdack", mgmt_rdack_o, 1'b1);
        chk("rdata", mgmt_rdata_o, e);
    endtask

    task automatic sendchk(input logic exp, input logic [9:0] req,
                           input logic [9:0] m);
        repeat (12) begin
            @(posedge clk_i);
            #1;
            if (ctl_send_o === 1'b1) break;
        end
        chk("ctl send", ctl_send_o === 1'b1, exp);
        if (ctl_send_o === 1'b1) begin
            chk("ctl req", ctl_req_o & m, req & m);
            chk("src addr", ctl_src_addr_o, {a_hi[15:0], a_lo});
            repeat (8) @(posedge clk_i);
        end
    endtask

    // One frame with a settings write inside it, then the gap is counted
    task automatic frame_gap(input logic [7:0] dly, input int exp,
                             input logic [5:0] held, input logic [31:0] mid);
        int cnt;
        cnt = 0;
        @(posedge clk_i);
        ifg_delay_i <= dly;
        tx_frame_start_i <= 1'b1;
        @(posedge clk_i);
        tx_frame_start_i <= 1'b0;
        wr(ADDR_TX_CFG, mid);
        repeat (2) @(posedge clk_i);
        #1;
        chk("cfg held", tx_cfg_o, held);
        @(posedge clk_i);
        tx_frame_end_i <= 1'b1;
        @(posedge clk_i);
        tx_frame_end_i <= 1'b0;
        repeat (60) begin
            @(posedge clk_i);
            #1;
            if (tx_gap_busy_o === 1'b1) cnt++;
        end
        chk("gap cycles", cnt, exp);
        chk("cfg after", tx_cfg_o, mid[30:25]);
        $display("done frame gap %0d", exp);
    endtask

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        test_done;
    end

    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdchk(ADDR_TX_CFG, TX_CFG_RESET);
        rdchk(ADDR_FC_CFG, FC_RESET_PFC);
        rdchk(ADDR_PAUSE_LO, 32'hFFFF_FFFF);
        rdchk(ADDR_PAUSE_HI, 32'h0000_FFFF);
        rdchk(12'h410, 32'h0000_0000);
        $display("done reset values");
        for (n = 0; n < 6; n++) begin
            d = (n == 0) ? 32'h7E00_0000 : $random(seed) & 32'h7FFF_FFFF;
            wr(ADDR_TX_CFG, d);
            rdchk(ADDR_TX_CFG, d & TX_CFG_WMASK);
            chk("tx cfg", tx_cfg_o, d[30:25]);
        end
        wr(ADDR_TX_CFG, 32'hFFFF_FFFF);
        #1;
        chk("tx reset", tx_reset_o, 1'b1);
        rdchk(ADDR_TX_CFG, TX_CFG_RESET);
        chk("tx cfg reset", tx_cfg_o, 6'b001000);
        $display("done transmit settings");
        frame_gap(8'd40, MIN_IFG_CYCLES, 6'b001000, 32'h1200_0000);
        d = 13 + ({$random(seed)} % 32);
        frame_gap(d[7:0], d, 6'b001001, 32'h1200_0000);
        frame_gap(8'd5, MIN_IFG_CYCLES, 6'b001001, 32'h1200_0000);
        a_lo = $random(seed);
        a_hi = $random(seed);
        wr(ADDR_PAUSE_LO, a_lo);
        wr(ADDR_PAUSE_HI, a_hi);
        rdchk(ADDR_PAUSE_HI, a_hi & PAUSE_HI_WMASK);
        for (n = 0; n < 3; n++) begin
            d = (n == 0) ? 32'h0 : (n == 1) ? 32'h4000_0000 : 32'h4010_0000;
            ack_dly <= n[3:0];
            wr(ADDR_FC_CFG, d);
            @(posedge clk_i);
            pause_request_i <= 1'b1;
            sendchk(n != 0, 10'h000, 10'h3FF);
            @(posedge clk_i);
            pause_request_i <= 1'b0;
            sendchk(n == 2, 10'h100, 10'h3FF);
        end
        $display("done legacy pause");
        for (n = 0; n < 13; n++) begin
            d = (n < 8) ? 32'h0400_FF00 :
                32'h0400_0000 | ($random(seed) & 32'hFF00);
            if (n == 12) d = 32'h0000_FF00;
            r = (n < 8) ? 32'h1 << n : $random(seed);
            ack_dly <= {2'b00, n[1:0]};
            wr(ADDR_FC_CFG, d);
            @(posedge clk_i);
            xmit_prio_pause_valid_i <= r[7:0];
            sendchk((r[7:0] & d[15:8]) != 0 && d[26],
                    {2'b10, r[7:0] & d[15:8]}, 10'h3FF);
            @(posedge clk_i);
            xmit_prio_pause_valid_i <= 8'h00;
            sendchk((r[7:0] & d[15:8]) != 0 && d[26], 10'h200, 10'h2FF);
        end
        $display("done priority transmit");
        for (n = 0; n < 6; n++) begin
            d = $random(seed) & 32'h0200_00FF;
            if (n < 2) d = n ? 32'h0000_00FF : 32'h0200_00FF;
            r = $random(seed);
            wr(ADDR_FC_CFG, d);
            @(posedge clk_i);
            rx_pfc_frame_i <= 1'b1;
            rx_pfc_quanta_valid_i <= r[7:0];
            @(posedge clk_i);
            rx_pfc_frame_i <= 1'b0;
            #1;
            chk("recv valid", recv_prio_pause_valid_o,
                d[25] ? r[7:0] & d[7:0] : 8'h00);
            chk("rx pass", rx_ctl_pass_o, !d[25]);
        end
        for (n = 0; n < 2; n++) begin
            wr(ADDR_FC_CFG, n ? 32'h2000_0000 : 32'h0);
            @(posedge clk_i);
            rx_pause_frame_i <= 1'b1;
            rx_pause_quanta_i <= 16'h0003;
            @(posedge clk_i);
            rx_pause_frame_i <= 1'b0;
            #1;
            chk("inhibit", tx_inhibit_o, n[0]);
            chk("pass", rx_ctl_pass_o, !n[0]);
            repeat (4) @(posedge clk_i);
            #1;
            chk("inhibit end", tx_inhibit_o, 1'b0);
        end
        $display("done receive side");
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdchk(ADDR_FC_CFG, FC_RESET_PFC);
        $display("done second reset");
        test_done;
    end
endmodule
